// ---- hrs_pkg.sv ----
// Shared constants for the hardware return stack
package hrs_pkg;
  localparam int HRS_DEPTH = 16;
  localparam int HRS_PC_W = 15;
  localparam int HRS_IDX_W = 4;
  localparam int HRS_PTR_W = 5;
  localparam logic [4:0] HRS_PTR_RESET = 5'h1F;
  localparam logic [4:0] HRS_PTR_FULL = 5'h0F;
  localparam logic [3:0] HRS_WRAP_IDX = 4'hF;
  // Register offsets on the plain register port
  localparam logic [2:0] HRS_OFS_TOP_LOW = 3'h0;
  localparam logic [2:0] HRS_OFS_TOP_HIGH = 3'h1;
  localparam logic [2:0] HRS_OFS_PTR = 3'h2;
  localparam logic [2:0] HRS_OFS_STATUS = 3'h3;
  localparam logic [2:0] HRS_OFS_MASK = 3'h4;
  // Status and mask field positions
  localparam int HRS_BIT_OVF = 0;
  localparam int HRS_BIT_UNF = 1;
  localparam logic [1:0] HRS_MASK_RESET = 2'h0;
  localparam logic [7:0] HRS_TOP_EMPTY = 8'h00;
endpackage : hrs_pkg

// ---- hrs_mem.sv ----
// Sixteen-entry storage for the return stack, registered read
`timescale 1ns/1ps
`default_nettype none
module hrs_mem
  import hrs_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [HRS_IDX_W-1:0] i_wr_idx,
  input wire logic [HRS_PC_W-1:0] i_wr_data,
  // Read port
  input wire logic [HRS_IDX_W-1:0] i_rd_idx,
  output logic [HRS_PC_W-1:0] o_rd_data
);
  logic [HRS_PC_W-1:0] mem_reg [HRS_DEPTH];

  // Storage has no reset; contents are undefined until pushed
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem_reg[i_wr_idx] <= i_wr_data;
    end
    o_rd_data <= mem_reg[i_rd_idx];
  end
endmodule : hrs_mem
`default_nettype wire

// ---- hrs_stack.sv ----
// Hardware return-address stack with pointer, flags and register port
// Notes on behaviour
// - Sixteen entries of fifteen-bit program counter.
// - Storage private, not on data addressing.
// - Call, call-via-working, interrupt push counter.
// - Return variants pop into program counter.
// - Push and pop leave upper hold untouched.
// - Fault reset disabled means circular buffer.
// - Seventeenth push overwrites the first entry.
// - Flags set on overflow and underflow always.
// - Top pair read/write; pointer selects entry.
// - Pointer five bits to detect faults.
// - Calls increment pointer; returns decrement it.
// - Increment then store; load then decrement.
// - Reset empties stack, pointer at 1F.
// - Empty with fault reset: top reads zero.
// - Empty without fault reset: entry 0F.
`timescale 1ns/1ps
`default_nettype none
module hrs_stack
  import hrs_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Configuration
  input wire logic i_stack_fault_reset_enable,
  // Core sequencer
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [HRS_PC_W-1:0] i_push_pc,
  output logic [HRS_PC_W-1:0] o_pop_pc,
  // Register port
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Status outputs
  output logic o_stack_overflow_flag,
  output logic o_stack_underflow_flag,
  output logic o_reset_request,
  output logic o_irq
);
  logic [HRS_PTR_W-1:0] stack_pointer_reg;
  logic [HRS_PTR_W-1:0] stack_pointer_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic reset_req_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic byp_valid_reg;
  logic [HRS_PC_W-1:0] byp_data_reg;
  logic [HRS_PC_W-1:0] ptr_entry_q;
  logic [HRS_PC_W-1:0] mem_rd;

  // Index decode shared by every access
  function automatic logic [HRS_IDX_W-1:0] idx_of(input logic [HRS_PTR_W-1:0] p);
    idx_of = p[HRS_IDX_W-1:0];
  endfunction : idx_of

  wire logic [HRS_PTR_W-1:0] ptr_inc = stack_pointer_reg + 5'h01;
  wire logic [HRS_PTR_W-1:0] ptr_dec = stack_pointer_reg - 5'h01;
  wire logic is_empty = (stack_pointer_reg == HRS_PTR_RESET);
  wire logic is_full = (stack_pointer_reg == HRS_PTR_FULL);
  // Push wins if both strobes collide; the core never issues both
  wire logic do_push = i_push;
  wire logic do_pop = i_pop & ~i_push;
  wire logic push_ovf = do_push & is_full;
  wire logic pop_unf = do_pop & is_empty;
  wire logic ptr_wr = i_reg_wr & (i_reg_addr == HRS_OFS_PTR);
  wire logic top_lo_wr = i_reg_wr & (i_reg_addr == HRS_OFS_TOP_LOW);
  wire logic top_hi_wr = i_reg_wr & (i_reg_addr == HRS_OFS_TOP_HIGH);
  wire logic status_rd = i_reg_rd & (i_reg_addr == HRS_OFS_STATUS);

  // pointer moves; wrap via low four bits
  always_comb begin
    stack_pointer_next = stack_pointer_reg;
    if (ptr_wr) begin
      stack_pointer_next = i_reg_wdata[HRS_PTR_W-1:0];
    end else if (do_push) begin
      stack_pointer_next = is_empty ? 5'h00 : ptr_inc;
    end else if (do_pop) begin
      stack_pointer_next = ptr_dec;
    end
  end

  // push stores at the incremented pointer's entry
  wire logic [HRS_IDX_W-1:0] push_idx = idx_of(stack_pointer_next);
  wire logic [HRS_IDX_W-1:0] top_idx = idx_of(stack_pointer_reg);
  // software writes merge one byte into the selected entry
  wire logic [HRS_PC_W-1:0] sw_entry = top_hi_wr ?
    {i_reg_wdata[6:0], ptr_entry_q[7:0]} : {ptr_entry_q[14:8], i_reg_wdata};
  wire logic mem_we = do_push | top_lo_wr | top_hi_wr;
  wire logic [HRS_IDX_W-1:0] mem_widx = do_push ? push_idx : top_idx;
  wire logic [HRS_PC_W-1:0] mem_wdata = do_push ? i_push_pc : sw_entry;

  hrs_mem hrs_mem_inst (
    .i_sys_clk(i_sys_clk),
    .i_wr_en(mem_we),
    .i_wr_idx(mem_widx),
    .i_wr_data(mem_wdata),
    .i_rd_idx(idx_of(stack_pointer_next)),
    .o_rd_data(mem_rd)
  );

  // Memory reads the old word when the top is written; bypass for one cycle
  wire logic byp_hit = mem_we & (mem_widx == idx_of(stack_pointer_next));
  assign ptr_entry_q = byp_valid_reg ? byp_data_reg : mem_rd;

  // Bypass register holds the word just written under the new pointer
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      byp_valid_reg <= 1'b0;
      byp_data_reg <= 15'h0000;
    end else begin
      byp_valid_reg <= byp_hit;
      byp_data_reg <= mem_wdata;
    end
  end

  // pop returns the entry before decrement; untouched
  assign o_pop_pc = ptr_entry_q;

  // empty-state view of the top pair
  wire logic top_zero = is_empty & i_stack_fault_reset_enable;
  wire logic [HRS_PC_W-1:0] top_view = top_zero ? {7'h00, HRS_TOP_EMPTY} : ptr_entry_q;

  // sticky flags; set beats the read clear
  assign status_next = (status_rd ? 2'h0 : status_reg) | {pop_unf, push_ovf};

  // Read data mux, registered for next-cycle return
  always_comb begin
    rdata_next = 8'h00;
    unique case (i_reg_addr)
      HRS_OFS_TOP_LOW: rdata_next = top_view[7:0];
      HRS_OFS_TOP_HIGH: rdata_next = {1'b0, top_view[14:8]};
      HRS_OFS_PTR: rdata_next = {3'h0, stack_pointer_reg};
      HRS_OFS_STATUS: rdata_next = {6'h00, status_reg};
      HRS_OFS_MASK: rdata_next = {6'h00, mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // reset empties the stack; registers held short
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stack_pointer_reg <= HRS_PTR_RESET;
      status_reg <= 2'h0;
      mask_reg <= HRS_MASK_RESET;
      rdata_reg <= 8'h00;
      reset_req_reg <= 1'b0;
    end else begin
      stack_pointer_reg <= stack_pointer_next;
      status_reg <= status_next;
      rdata_reg <= i_reg_rd ? rdata_next : 8'h00;
      if (i_reg_wr && i_reg_addr == HRS_OFS_MASK) begin
        mask_reg <= i_reg_wdata[1:0];
      end
      // fault requests a device reset when enabled
      reset_req_reg <= i_stack_fault_reset_enable & (push_ovf | pop_unf);
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_stack_overflow_flag = status_reg[HRS_BIT_OVF];
  assign o_stack_underflow_flag = status_reg[HRS_BIT_UNF];
  assign o_reset_request = reset_req_reg;
  // circular mode suppresses the reset request and the zeroed empty top; irq is unaffected
  assign o_irq = |(status_reg & mask_reg);

  // Assertions
  property ptr_reset_p;
    @(posedge i_sys_clk) $rose(i_sys_rst) |=> stack_pointer_reg == 5'h1F;
  endproperty
  ptr_after_reset_a: assert property (ptr_reset_p) else $error("pointer not 1F after reset");
  push_incr_ptr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_push && !ptr_wr && !is_empty) |=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h01)
    else $error("push did not increment pointer");
  pop_decr_ptr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (do_pop && !ptr_wr) |=> stack_pointer_reg == $past(stack_pointer_reg) - 5'h01)
    else $error("pop did not decrement pointer");
  ovf_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    push_ovf |=> o_stack_overflow_flag) else $error("overflow flag not set");
  unf_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    pop_unf |=> o_stack_underflow_flag) else $error("underflow flag not set");
  reset_req_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (push_ovf || pop_unf) |=> o_reset_request == $past(i_stack_fault_reset_enable))
    else $error("reset request mismatch");
  empty_top_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_reg_rd && top_zero && i_reg_addr == HRS_OFS_TOP_LOW) |=> o_reg_rdata == 8'h00)
    else $error("empty top not zero");
  push_wraps_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (do_push && is_full && !ptr_wr) |=> stack_pointer_reg == 5'h10)
    else $error("pointer wrap wrong");
endmodule : hrs_stack
`default_nettype wire

// ---- hrs_core_model.sv ----
// Core sequencer model: call, interrupt entry and return pulses
`timescale 1ns/1ps
`default_nettype none
module hrs_core_model
  import hrs_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Stack port
  input wire logic [HRS_PC_W-1:0] i_pop_pc,
  output logic o_push,
  output logic o_pop,
  output logic [HRS_PC_W-1:0] o_push_pc
);
  // Idle at time zero
  initial begin
    o_push = 1'b0;
    o_pop = 1'b0;
    o_push_pc = '0;
  end
  // Push pulse; released pc turns to its inverse
  task automatic call_entry(input logic [HRS_PC_W-1:0] pc);
    @(posedge i_sys_clk);
    o_push <= 1'b1;
    o_push_pc <= pc;
    @(posedge i_sys_clk);
    o_push <= 1'b0;
    o_push_pc <= ~pc;
  endtask : call_entry
  // Pop pulse; top entry taken inside the pop cycle
  task automatic return_op(output logic [HRS_PC_W-1:0] pc);
    @(posedge i_sys_clk);
    o_pop <= 1'b1;
    #1 pc = i_pop_pc;
    @(posedge i_sys_clk);
    o_pop <= 1'b0;
  endtask : return_op
endmodule : hrs_core_model
`default_nettype wire

// ---- hrs_stack_tb.sv ----
// Self-checking testbench for the hardware return stack
`timescale 1ns/1ps
`default_nettype none
module hrs_stack_tb
  import hrs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fre = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic push, pop, ovf, unf, rreq, irq;
  logic [HRS_PC_W-1:0] push_pc, pop_pc, got;
  logic [7:0] rdata, d;
  int num_errors = 0;
  int num_checks = 0;
  int nreq = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Count reset request cycles
  always @(posedge clk) if (rreq === 1'b1) nreq <= nreq + 1;
  hrs_stack hrs_stack_inst (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_stack_fault_reset_enable(fre), .i_push(push), .i_pop(pop),
    .i_push_pc(push_pc), .o_pop_pc(pop_pc), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_stack_overflow_flag(ovf), .o_stack_underflow_flag(unf),
    .o_reset_request(rreq), .o_irq(irq));
  hrs_core_model hrs_core_model_inst (.i_sys_clk(clk), .i_pop_pc(pop_pc),
    .o_push(push), .o_pop(pop), .o_push_pc(push_pc));
  function automatic logic [14:0] pcv(input int i);
    return 15'h4100 + 15'(i * 257);
  endfunction : pcv
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Register bus: one-cycle strobes, data the cycle after a read
  task automatic rdr(input logic [2:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rdr
  task automatic wrr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic t_pushpop;
    rdr(HRS_OFS_PTR);
    chk("reset ptr", 5'h1F, d);
    chk("reset outs", 4'h0, {ovf, unf, rreq, irq});
    hrs_core_model_inst.call_entry(pcv(1));
    hrs_core_model_inst.call_entry(pcv(2));
    rdr(HRS_OFS_PTR);
    chk("ptr after push", 5'h01, d);
    hrs_core_model_inst.return_op(got);
    chk("pop pc", pcv(2), got);
    hrs_core_model_inst.return_op(got);
    chk("pop pc", pcv(1), got);
    // Pointer moved only with no call pending
    wrr(HRS_OFS_PTR, 8'h00);
    wrr(HRS_OFS_TOP_LOW, 8'h5A);
    wrr(HRS_OFS_TOP_HIGH, 8'h12);
    rdr(HRS_OFS_TOP_HIGH);
    chk("top high", 8'h12, d);
    hrs_core_model_inst.return_op(got);
    chk("pop written", 15'h125A, got);
    $display("test push pop done");
  endtask : t_pushpop
  task automatic t_circular;
    @(posedge clk);
    fre <= 1'b0;
    for (int i = 1; i <= 17; i++) hrs_core_model_inst.call_entry(pcv(i));
    #1 chk("ovf flag", 1'b1, ovf);
    chk("no reset", 0, nreq);
    rdr(HRS_OFS_PTR);
    chk("ptr ovf", 5'h10, d);
    wrr(HRS_OFS_PTR, 8'h00);
    rdr(HRS_OFS_TOP_LOW);
    chk("entry0 low", pcv(17) & 15'hFF, d);
    rdr(HRS_OFS_TOP_HIGH);
    chk("entry0 high", pcv(17) >> 8, d);
    wrr(HRS_OFS_PTR, 8'h1F);
    rdr(HRS_OFS_TOP_LOW);
    chk("empty circ", pcv(16) & 15'hFF, d);
    @(posedge clk);
    fre <= 1'b1;
    rdr(HRS_OFS_TOP_LOW);
    chk("empty fault", 8'h00, d);
    $display("test circular done");
  endtask : t_circular
  task automatic t_fault;
    wrr(HRS_OFS_MASK, 8'h01);
    #1 chk("irq ovf", 1'b1, irq);
    rdr(HRS_OFS_STATUS);
    chk("status", 8'h01, d);
    chk("irq clear", 1'b0, irq);
    hrs_core_model_inst.return_op(got);
    repeat (3) @(posedge clk);
    #1 chk("unf flag", 1'b1, unf);
    chk("one reset pulse", 1, nreq);
    chk("irq masked", 1'b0, irq);
    wrr(HRS_OFS_MASK, 8'h03);
    #1 chk("irq unf", 1'b1, irq);
    rdr(3'h7);
    chk("unmapped", 8'h00, d);
    $display("test fault done");
  endtask : t_fault
  // Main sequence after 8 reset cycles
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_pushpop;
    t_circular;
    t_fault;
    conclude;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule : hrs_stack_tb
`default_nettype wire
